// file: isd_consts.svh
// constants for the isochronous split descriptor scheduler
`ifndef ISD_CONSTS_SVH
`define ISD_CONSTS_SVH

// ==========================================================
// register byte offsets
`define ISD_OFS_CTRL 6'h00
`define ISD_OFS_FRAME 6'h04
`define ISD_OFS_CSM 6'h08
`define ISD_OFS_USTAT 6'h0C
`define ISD_OFS_CNT_LO 6'h10
`define ISD_OFS_CNT_HI 6'h14
`define ISD_OFS_SUM 6'h18
`define ISD_OFS_IRQ_STS 6'h1C
`define ISD_OFS_IRQ_EN 6'h20
`define ISD_OFS_IRQ_CLR 6'h24

// ==========================================================
// field positions, widths and counts
`define ISD_CTRL_ACT 0
`define ISD_CTRL_IN 1
`define ISD_FRM_MSB 7
`define ISD_FRM_LSB 3
`define ISD_RC_XERR 0
`define ISD_RC_BABL 1
`define ISD_RC_UNDR 2
`define ISD_RC_W 3
`define ISD_CNT_W 8
`define ISD_UF_NUM 8
`define ISD_IRQ_DONE 0
`define ISD_IRQ_ERR 1
`define ISD_IRQ_HALT 2
`define ISD_IRQ_W 3

// ==========================================================
// reset values
`define ISD_RST_BYTE 8'h00
`define ISD_RST_CODES 24'h000000
`define ISD_RST_CNT 64'h0000000000000000
`define ISD_RST_WORD 32'h00000000
`define ISD_RST_IRQ 3'h0

`endif

// file: isd_pkg.sv
// types of the isochronous split descriptor scheduler
`default_nettype none

package isd_pkg;

   typedef enum logic [1:0] {
      ISD_IDLE,
      ISD_SS,
      ISD_CS
   } isd_state_e;

   typedef struct packed {
      isd_state_e st;
      logic [2:0] uf;
      logic cs_due;
      logic act;
      logic tok_in;
      logic [7:0] frm;
      logic [7:0] ssm;
      logic [7:0] arm;
      logic [7:0] csm;
      logic [23:0] codes;
      logic [63:0] cnt;
      logic sum_xe;
      logic sum_bb;
      logic halt;
      logic sc;
      logic req;
      logic req_cs;
      logic req_in;
      logic wreq;
      logic [31:0] rdata;
   } isd_sched_s;

   typedef struct packed {
      logic [2:0] sts;
      logic [2:0] en;
      logic irq;
   } isd_irq_s;

endpackage : isd_pkg

`default_nettype wire

// file: isd_irq.sv
// sticky event status, enable mask and level interrupt
`include "isd_consts.svh"
`default_nettype none

module isd_irq (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [2:0] ev_i,
   input wire logic en_wr_i,
   input wire logic clr_wr_i,
   input wire logic [2:0] wdata_i,
   output logic [2:0] sts_o,
   output logic [2:0] en_o,
   output logic irq_o
);

   isd_pkg::isd_irq_s q;
   isd_pkg::isd_irq_s d;

   // ==========================================================
   // status and mask
   always_comb begin
      d = q;
      // a new event beats a clear in the same cycle
      if (clr_wr_i) begin
         d.sts = q.sts & ~wdata_i;
      end
      d.sts = d.sts | ev_i;
      if (en_wr_i) begin
         d.en = wdata_i;
      end
      d.irq = |(d.sts & d.en);
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q.sts <= `ISD_RST_IRQ;
         q.en <= `ISD_RST_IRQ;
         q.irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign sts_o = q.sts;
   assign en_o = q.en;
   assign irq_o = q.irq;

endmodule : isd_irq

`default_nettype wire

// file: isd_sched.sv
// isochronous split descriptor microframe scheduler, top
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`include "isd_consts.svh"
`default_nettype none

module isd_sched (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic sof_i,
   input wire logic [4:0] frame_num_i,
   input wire logic [2:0] uframe_i,
   output logic split_req_o,
   output logic split_cs_o,
   output logic split_in_o,
   output logic [2:0] split_uf_o,
   input wire logic res_valid_i,
   input wire logic [7:0] res_count_i,
   input wire logic res_xact_err_i,
   input wire logic res_babble_i,
   input wire logic res_underrun_i,
   input wire logic res_stall_i,
   output logic irq_o
);

   isd_pkg::isd_sched_s q;
   isd_pkg::isd_sched_s d;

   logic wr_go;
   logic rd_go;
   logic match;
   logic busy;
   logic ss_go;
   logic cs_go;
   logic stall_set;
   logic [2:0] code;
   logic [2:0] ev;
   logic [2:0] irq_sts;
   logic [2:0] irq_en;
   logic en_wr;
   logic clr_wr;

   // ==========================================================
   // scheduler and register file
   always_comb begin
      d = q;
      d.req = 1'b0;
      ev = `ISD_RST_IRQ;
      stall_set = 1'b0;
      wr_go = avs_write_i && !q.wreq;
      rd_go = avs_read_i && q.wreq;
      busy = (q.st != isd_pkg::ISD_IDLE);
      match = (q.frm[`ISD_FRM_MSB:`ISD_FRM_LSB]
               == frame_num_i);
      ss_go = q.ssm[uframe_i];
      cs_go = q.tok_in && q.csm[uframe_i];
      code[`ISD_RC_XERR] = res_xact_err_i;
      code[`ISD_RC_BABL] = res_babble_i && q.tok_in;
      code[`ISD_RC_UNDR] = res_underrun_i && !q.tok_in;

      // one-cycle acknowledge: waitrequest drops for a single edge
      d.wreq = !((avs_read_i || avs_write_i) && q.wreq);

      case (q.st)
         isd_pkg::ISD_IDLE: begin
            // a late sof while busy is dropped, not queued
            if (sof_i && q.act && match) begin
               d.uf = uframe_i;
               d.cs_due = cs_go;
               d.req_in = q.tok_in;
               if (ss_go) begin
                  d.st = isd_pkg::ISD_SS;
                  d.req = 1'b1;
                  d.req_cs = 1'b0;
               end else if (cs_go) begin
                  d.st = isd_pkg::ISD_CS;
                  d.req = 1'b1;
                  d.req_cs = 1'b1;
               end
            end
         end
         isd_pkg::ISD_SS,
         isd_pkg::ISD_CS: begin
            if (res_valid_i) begin
               d.sc = q.req_cs;
               if (q.arm[q.uf]) begin
                  d.cnt[q.uf*`ISD_CNT_W +: `ISD_CNT_W] =
                     res_count_i;
                  d.codes[q.uf*`ISD_RC_W +: `ISD_RC_W] =
                     code;
               end
               if (q.st == isd_pkg::ISD_SS) begin
                  d.ssm[q.uf] = 1'b0;
               end else begin
                  d.csm[q.uf] = 1'b0;
               end
               ev[`ISD_IRQ_ERR] = |code;
               if (res_stall_i) begin
                  stall_set = 1'b1;
                  ev[`ISD_IRQ_HALT] = 1'b1;
                  d.act = 1'b0;
               end
               if (q.st == isd_pkg::ISD_SS && q.cs_due
                   && !res_stall_i) begin
                  // complete split due in this same microframe
                  d.st = isd_pkg::ISD_CS;
                  d.req = 1'b1;
                  d.req_cs = 1'b1;
               end else begin
                  d.st = isd_pkg::ISD_IDLE;
               end
               if (q.act && d.ssm == `ISD_RST_BYTE
                   && (!q.tok_in || d.csm == `ISD_RST_BYTE)) begin
                  d.act = 1'b0;
                  ev[`ISD_IRQ_DONE] = 1'b1;
               end
            end
         end
         default: begin
            d.st = isd_pkg::ISD_IDLE;
         end
      endcase

      if (stall_set) begin
         d.halt = 1'b1;
      end

      // software writes come last so a set beats a hardware clear
      if (wr_go) begin
         if (avs_address_i == `ISD_OFS_CTRL) begin
            d.act = avs_writedata_i[`ISD_CTRL_ACT];
            d.tok_in = avs_writedata_i[`ISD_CTRL_IN];
         end else if (avs_address_i == `ISD_OFS_FRAME) begin
            d.frm = avs_writedata_i[7:0];
         end else if (avs_address_i == `ISD_OFS_CSM) begin
            d.csm = avs_writedata_i[7:0];
         end else if (avs_address_i == `ISD_OFS_USTAT) begin
            d.ssm = avs_writedata_i[7:0];
            d.arm = avs_writedata_i[7:0];
            d.codes = avs_writedata_i[31:8];
         end else if (avs_address_i == `ISD_OFS_SUM) begin
            // halt clears on write unless a stall lands now
            d.halt = stall_set;
            // a result landing now keeps its split kind
            d.sc = busy && res_valid_i && q.req_cs;
         end
      end

      d.sum_xe = 1'b0;
      d.sum_bb = 1'b0;
      for (int i = 0; i < `ISD_UF_NUM; i++) begin
         d.sum_xe = d.sum_xe
                    | d.codes[i*`ISD_RC_W + `ISD_RC_XERR];
         d.sum_bb = d.sum_bb
                    | d.codes[i*`ISD_RC_W + `ISD_RC_BABL];
      end

      if (rd_go) begin
         if (avs_address_i == `ISD_OFS_CTRL) begin
            d.rdata = {30'h0, q.tok_in, q.act};
         end else if (avs_address_i == `ISD_OFS_FRAME) begin
            d.rdata = {24'h0, q.frm};
         end else if (avs_address_i == `ISD_OFS_CSM) begin
            d.rdata = {24'h0, q.csm};
         end else if (avs_address_i == `ISD_OFS_USTAT) begin
            d.rdata = {q.codes, q.ssm};
         end else if (avs_address_i == `ISD_OFS_CNT_LO) begin
            d.rdata = q.cnt[31:0];
         end else if (avs_address_i == `ISD_OFS_CNT_HI) begin
            d.rdata = q.cnt[63:32];
         end else if (avs_address_i == `ISD_OFS_SUM) begin
            d.rdata = {28'h0, q.sc, q.halt, q.sum_bb, q.sum_xe};
         end else if (avs_address_i == `ISD_OFS_IRQ_STS) begin
            d.rdata = {29'h0, irq_sts};
         end else if (avs_address_i == `ISD_OFS_IRQ_EN) begin
            d.rdata = {29'h0, irq_en};
         end else begin
            d.rdata = `ISD_RST_WORD;
         end
      end
   end

   assign en_wr = wr_go && (avs_address_i == `ISD_OFS_IRQ_EN);
   assign clr_wr = wr_go && (avs_address_i == `ISD_OFS_IRQ_CLR);

   // ==========================================================
   // state register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q.st <= isd_pkg::ISD_IDLE;
         q.uf <= 3'h0;
         q.cs_due <= 1'b0;
         q.act <= 1'b0;
         q.tok_in <= 1'b0;
         q.frm <= `ISD_RST_BYTE;
         q.ssm <= `ISD_RST_BYTE;
         q.arm <= `ISD_RST_BYTE;
         q.csm <= `ISD_RST_BYTE;
         q.codes <= `ISD_RST_CODES;
         q.cnt <= `ISD_RST_CNT;
         q.sum_xe <= 1'b0;
         q.sum_bb <= 1'b0;
         q.halt <= 1'b0;
         q.sc <= 1'b0;
         q.req <= 1'b0;
         q.req_cs <= 1'b0;
         q.req_in <= 1'b0;
         q.wreq <= 1'b1;
         q.rdata <= `ISD_RST_WORD;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata_o = q.rdata;
   assign avs_waitrequest_o = q.wreq;
   assign split_req_o = q.req;
   assign split_cs_o = q.req_cs;
   assign split_in_o = q.req_in;
   assign split_uf_o = q.uf;

   // ==========================================================
   // interrupt
   isd_irq u_irq (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .ev_i(ev),
      .en_wr_i(en_wr),
      .clr_wr_i(clr_wr),
      .wdata_i(avs_writedata_i[2:0]),
      .sts_o(irq_sts),
      .en_o(irq_en),
      .irq_o(irq_o)
   );

   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_issue;
      sof_i && !busy && q.act && match;
   endsequence

   sequence s_result;
      busy && res_valid_i && !wr_go;
   endsequence

   a_ss_issue: assert property (
      (s_issue ##0 q.ssm[uframe_i]) |=> split_req_o
         && !split_cs_o && split_uf_o == $past(uframe_i))
      else $error("start split not issued");

   a_cs_issue: assert property (
      (s_issue ##0 !q.ssm[uframe_i] && q.tok_in
         && q.csm[uframe_i]) |=> split_req_o && split_cs_o)
      else $error("complete split not issued");

   a_cs_out_skip: assert property (
      (s_issue ##0 !q.tok_in && !q.ssm[uframe_i])
         |=> !split_req_o)
      else $error("split issued for out descriptor");

   a_frame_gate: assert property (
      sof_i && !busy && !match |=> !split_req_o)
      else $error("split issued on frame mismatch");

   a_ss_clear: assert property (
      (s_result ##0 q.st == isd_pkg::ISD_SS)
         |=> !q.ssm[$past(q.uf)])
      else $error("start split mask not cleared");

   a_cs_clear: assert property (
      (s_result ##0 q.st == isd_pkg::ISD_CS)
         |=> !q.csm[$past(q.uf)])
      else $error("complete split mask not cleared");

   a_count_wr: assert property (
      (s_result ##0 q.arm[q.uf]) |=>
         q.cnt[$past(q.uf)*8 +: 8] == $past(res_count_i))
      else $error("received count not written");

   a_code_hold: assert property (
      (s_result ##0 !q.arm[q.uf])
         |=> $stable(q.codes) && $stable(q.cnt))
      else $error("unarmed microframe result changed");

   a_code_babl: assert property (
      (s_result ##0 q.arm[q.uf] && !q.tok_in)
         |=> !q.codes[$past(q.uf)*3 + 1])
      else $error("babble recorded on out");

   a_code_pos: assert property (
      rd_go && avs_address_i == `ISD_OFS_USTAT
         |=> avs_readdata_o[13:11] == $past(q.codes[5:3]))
      else $error("result code misplaced");

   a_sum_babl: assert property (
      (s_result ##0 q.arm[q.uf] && q.tok_in && res_babble_i)
         |=> ##1 q.sum_bb)
      else $error("summary babble not set");

   a_halt_set: assert property (
      busy && res_valid_i && res_stall_i
         |=> q.halt && !q.act ##1 !split_req_o)
      else $error("halt not set on stall");

   a_cs_follow: assert property (
      (s_result ##0 q.st == isd_pkg::ISD_SS && q.cs_due && !res_stall_i)
         |=> split_req_o && split_cs_o && split_uf_o == $past(q.uf))
      else $error("follow-up complete split missing");

   a_stall_event: assert property (
      busy && res_valid_i && res_stall_i |=> irq_sts[`ISD_IRQ_HALT])
      else $error("halt event not raised");

   a_bus_ack: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o
         |=> !avs_waitrequest_o)
      else $error("bus not acknowledged");

endmodule : isd_sched

`default_nettype wire

// file: isd_dev_model.sv
// downstream split device model answering each split with one result
`default_nettype none

module isd_dev_model (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic split_req_i,
   input wire logic [2:0] split_uf_i,
   input wire logic [3:0] dly_i,
   input wire logic [7:0] cnt_base_i,
   input wire logic [3:0] flags_i,
   output logic res_valid_o,
   output logic [7:0] res_count_o,
   output logic [3:0] res_flags_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy_q;
   logic [3:0] wait_q;
   logic [2:0] uf_q;

   // ==========================================================
   // answer after a programmable delay
   // idle result lines toggle so a design that samples without
   // the valid pulse sees garbage rather than a stale result
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_q <= 1'b0;
         wait_q <= 4'h0;
         uf_q <= 3'h0;
         res_valid_o <= 1'b0;
         res_count_o <= 8'h00;
         res_flags_o <= 4'h0;
      end else begin
         res_valid_o <= 1'b0;
         if (split_req_i) begin
            busy_q <= 1'b1;
            wait_q <= dly_i;
            uf_q <= split_uf_i;
         end else if (busy_q && wait_q == 4'h0) begin
            busy_q <= 1'b0;
            res_valid_o <= 1'b1;
            res_count_o <= cnt_base_i + {5'h00, uf_q};
            res_flags_o <= flags_i;
         end else begin
            wait_q <= wait_q - 4'h1;
            res_count_o <= ~res_count_o;
            res_flags_o <= ~res_flags_o;
         end
      end
   end
endmodule : isd_dev_model

`default_nettype wire

// file: tb.sv
// self-checking bench of the split descriptor scheduler
`include "isd_consts.svh"
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
   logic [5:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
   logic sof_i, split_req_o, split_cs_o, split_in_o, res_valid_i, irq_o;
   logic [4:0] frame_num_i;
   logic [2:0] uframe_i, split_uf_o;
   logic [7:0] res_count_i, cnt_base;
   logic [3:0] res_flags, flags, dly;
   int err_count, compares, n_split, i;
   localparam logic [5:0] OFS[8] = '{`ISD_OFS_CTRL, `ISD_OFS_USTAT,
      `ISD_OFS_CSM, `ISD_OFS_CNT_LO, `ISD_OFS_CNT_HI, `ISD_OFS_SUM,
      `ISD_OFS_IRQ_STS, 6'h3C};

   isd_sched u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .sof_i(sof_i),
      .frame_num_i(frame_num_i), .uframe_i(uframe_i),
      .split_req_o(split_req_o), .split_cs_o(split_cs_o),
      .split_in_o(split_in_o), .split_uf_o(split_uf_o),
      .res_valid_i(res_valid_i), .res_count_i(res_count_i),
      .res_xact_err_i(res_flags[0]), .res_babble_i(res_flags[1]),
      .res_underrun_i(res_flags[2]), .res_stall_i(res_flags[3]),
      .irq_o(irq_o));

   isd_dev_model u_dev (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .split_req_i(split_req_o), .split_uf_i(split_uf_o), .dly_i(dly),
      .cnt_base_i(cnt_base), .flags_i(flags), .res_valid_o(res_valid_i),
      .res_count_o(res_count_i), .res_flags_o(res_flags));

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   // split pulses stand one cycle, so one look per negedge counts each once
   always @(negedge mclk_i) if (split_req_o === 1'b1) n_split++;

   task automatic conclude;
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] wd);
      int k;
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= wd;
      avs_read_i <= !wr;
      avs_write_i <= wr;
      // outputs read here still hold their values from before this edge
      for (k = 0; k < 50; k++) begin
         @(posedge mclk_i);
         if (avs_waitrequest_o === 1'b0) break;
      end
      if (k == 50) begin err_count++; conclude(); end
      rdv = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000);
      `CHK(rdv, e)
   endtask : rd

   task automatic sof(input logic [4:0] f, input logic [2:0] u);
      @(posedge mclk_i);
      sof_i <= 1'b1;
      frame_num_i <= f;
      uframe_i <= u;
      @(posedge mclk_i);
      sof_i <= 1'b0;
   endtask : sof

   // expect one split, then let its result land
   task automatic ss(input logic cs, input logic [2:0] u, input logic in);
      int k;
      for (k = 0; k < 40; k++) begin
         @(negedge mclk_i);
         if (split_req_o === 1'b1) break;
      end
      if (k == 40) begin err_count++; conclude(); end
      `CHK(split_cs_o, cs)
      `CHK(split_uf_o, u)
      `CHK(split_in_o, in)
      repeat (14) @(posedge mclk_i);
   endtask : ss

   task automatic quiet(input int n);
      int n0;
      n0 = n_split;
      repeat (n) @(negedge mclk_i);
      `CHK(n_split, n0)
   endtask : quiet

   initial begin
      arst_n_i = 1'b0; avs_read_i = 1'b0; avs_write_i = 1'b0;
      avs_address_i = 6'h00; avs_writedata_i = 32'h00000000;
      sof_i = 1'b0; frame_num_i = 5'h00; uframe_i = 3'h0;
      dly = 4'h2; cnt_base = 8'h40; flags = 4'h6;
      err_count = 0; compares = 0; n_split = 0;
      repeat (5) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      for (i = 0; i < 8; i++) rd(OFS[i], 32'h00000000);
      wr(6'h3C, 32'hFFFFFFFF);
      rd(6'h3C, 32'h00000000);
      rd(`ISD_OFS_IRQ_CLR, 32'h00000000);
      // IN descriptor, start split in uf0 and complete split in uf2
      wr(`ISD_OFS_FRAME, 32'h00000048);
      wr(`ISD_OFS_USTAT, 32'h00000001);
      wr(`ISD_OFS_CSM, 32'h00000004);
      wr(`ISD_OFS_IRQ_EN, 32'h00000001);
      wr(`ISD_OFS_CTRL, 32'h00000003);
      sof(5'h08, 3'h0);
      quiet(10);
      sof(5'h09, 3'h0);
      ss(1'b0, 3'h0, 1'b1);
      sof(5'h09, 3'h1);
      quiet(10);
      sof(5'h09, 3'h2);
      ss(1'b1, 3'h2, 1'b1);
      rd(`ISD_OFS_USTAT, 32'h00000200);
      rd(`ISD_OFS_CSM, 32'h00000000);
      rd(`ISD_OFS_CNT_LO, 32'h00000040);
      rd(`ISD_OFS_SUM, 32'h0000000A);
      rd(`ISD_OFS_CTRL, 32'h00000002);
      `CHK(irq_o, 1'b1)
      wr(`ISD_OFS_IRQ_CLR, 32'h00000007);
      repeat (2) @(posedge mclk_i);
      `CHK(irq_o, 1'b0)
      // OUT descriptor with errors, complete-split mask must be ignored
      dly <= 4'h5; cnt_base <= 8'h10; flags <= 4'h7;
      wr(`ISD_OFS_FRAME, 32'h00000018);
      wr(`ISD_OFS_USTAT, 32'h0000000A);
      wr(`ISD_OFS_CSM, 32'h000000FF);
      wr(`ISD_OFS_IRQ_EN, 32'h00000002);
      wr(`ISD_OFS_CTRL, 32'h00000001);
      sof(5'h03, 3'h0);
      quiet(10);
      sof(5'h03, 3'h1);
      ss(1'b0, 3'h1, 1'b0);
      flags <= 4'h0;
      sof(5'h03, 3'h3);
      ss(1'b0, 3'h3, 1'b0);
      sof(5'h03, 3'h3);
      quiet(10);
      rd(`ISD_OFS_USTAT, 32'h00002800);
      rd(`ISD_OFS_CNT_LO, 32'h13001140);
      rd(`ISD_OFS_SUM, 32'h00000001);
      `CHK(irq_o, 1'b1)
      wr(`ISD_OFS_IRQ_CLR, 32'h00000007);
      repeat (2) @(posedge mclk_i);
      `CHK(irq_o, 1'b0)
      // stall halts the descriptor and drops the rest of the frame
      dly <= 4'h0; flags <= 4'h8;
      wr(`ISD_OFS_FRAME, 32'h00000048);
      wr(`ISD_OFS_USTAT, 32'h00000003);
      wr(`ISD_OFS_CSM, 32'h00000000);
      wr(`ISD_OFS_IRQ_EN, 32'h00000004);
      wr(`ISD_OFS_CTRL, 32'h00000003);
      sof(5'h09, 3'h0);
      ss(1'b0, 3'h0, 1'b1);
      sof(5'h09, 3'h1);
      quiet(10);
      rd(`ISD_OFS_SUM, 32'h00000004);
      rd(`ISD_OFS_CTRL, 32'h00000002);
      rd(`ISD_OFS_USTAT, 32'h00000002);
      `CHK(irq_o, 1'b1)
      wr(`ISD_OFS_SUM, 32'h00000000);
      rd(`ISD_OFS_SUM, 32'h00000000);
      // start and complete split of one microframe, back to back
      flags <= 4'h0;
      wr(`ISD_OFS_FRAME, 32'h00000048);
      wr(`ISD_OFS_USTAT, 32'h00000004);
      wr(`ISD_OFS_CSM, 32'h00000004);
      wr(`ISD_OFS_CTRL, 32'h00000003);
      i = n_split;
      sof(5'h09, 3'h2);
      ss(1'b0, 3'h2, 1'b1);
      `CHK(n_split, i + 2)
      `CHK(split_cs_o, 1'b1)
      rd(`ISD_OFS_SUM, 32'h00000008);
      rd(`ISD_OFS_CNT_LO, 32'h13121110);
      rd(`ISD_OFS_CTRL, 32'h00000002);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      err_count++;
      conclude();
   end
endmodule : tb

`default_nettype wire
